// [relay_card_model.sv]
// relay card model: stored setups and memory check answers
`timescale 1ns/1ps
module relay_card_model
	import relay_seq_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic [STEP_W-1:0] SETUP_ADDR_O,
	input wire logic MEM_CHECK_START_O,
	input wire logic scratch_bad_i,
	output logic [NUM_ROWS*NUM_COLS-1:0] SETUP_DATA_I,
	output logic CODE_STORE_OK_I,
	output logic SCRATCH_STORE_OK_I,
	output logic MEM_CHECK_DONE_I
);
	logic [3:0] wait_ff;
	// each setup repeats its address, so a wrong index shows on the relays
	assign SETUP_DATA_I = {12{1'b1, SETUP_ADDR_O}};
	assign CODE_STORE_OK_I = 1'b1;
	// scratch failure on request, so the fault path gets exercised
	assign SCRATCH_STORE_OK_I = !scratch_bad_i;
	// answer 8 cycles after checks start, then every 16 cycles while they run, one answer per memory
	always_ff @(posedge CORE_CLK_I)
		wait_ff <= MEM_CHECK_START_O ? wait_ff + 4'h1 : 4'h0;
	assign MEM_CHECK_DONE_I = (wait_ff == 4'h8);
endmodule

// [relay_seq_pkg.sv]
// package of constants and types for the relay switch sequencer
package relay_seq_pkg;
	localparam int NUM_ROWS = 8;
	localparam int NUM_COLS = 12;
	localparam int NUM_STEPS = 100;
	localparam int STEP_W = 7;
	localparam int SETTLE_W = 16;
	localparam int CLK_HZ = 25000000;
	localparam int TICK_MS = 1;
	localparam int CYC_PER_MS = (CLK_HZ / 1000) * TICK_MS;
	localparam int MS_CNT_W = 15;
	localparam logic [SETTLE_W-1:0] SETTLE_MAX_MS = 16'hfde8;
	localparam logic [SETTLE_W-1:0] SETTLE_RST_MS = 16'h0000;
	localparam logic [SETTLE_W-1:0] HW_SETTLE_RST_MS = 16'h000f;
	localparam int BAD_ENTRY_US = 1000;
	localparam int BAD_ENTRY_CYC = (CLK_HZ / 1000000) * BAD_ENTRY_US;
	localparam int XFER_CYC = 16;
	localparam int LAMP_CYC = 64;
	localparam logic [STEP_W-1:0] STEP_RST = 7'h00;
	localparam logic [STEP_W-1:0] STEP_LAST = 7'h63;
	// row mode encoding
	localparam logic [1:0] MODE_DONT_CARE = 2'h0;
	localparam logic [1:0] MODE_CONNECT_FIRST = 2'h1;
	localparam logic [1:0] MODE_DISCONNECT_FIRST = 2'h2;
	typedef enum logic [2:0] {
		SW_IDLE,
		SW_XFER,
		SW_PH1,
		SW_PH2,
		SW_PH3,
		SW_PH4,
		SW_SETTLE
	} sw_state_e;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CODE,
		ST_SCRATCH,
		ST_LAMPS,
		ST_FAULT
	} test_state_e;
	typedef enum logic [1:0] {
		FD_IDLE,
		FD_CONFIRM
	} restore_state_e;
endpackage

// [relay_switch_sequencer.sv]
// crosspoint relay switching sequencer: row modes, phases, settling, self-check, restore
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module relay_switch_sequencer
	import relay_seq_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic SRST_I,
	input wire logic SETTLE_WR_I,
	input wire logic [SETTLE_W-1:0] SETTLE_MS_I,
	input wire logic [SETTLE_W-1:0] HW_SETTLE_MS_I,
	input wire logic ROW_SEL_VALID_I,
	input wire logic [2:0] ROW_SEL_I,
	input wire logic COL_SEL_I,
	input wire logic CONNECT_FIRST_KEY_I,
	input wire logic DISCONNECT_FIRST_KEY_I,
	input wire logic LINK_MODE_WR_I,
	input wire logic [2:0] LINK_ROW_I,
	input wire logic [1:0] LINK_MODE_I,
	input wire logic CHAIN_LEADER_I,
	input wire logic TRIG_ENABLE_KEY_I,
	input wire logic TRIGGER_I,
	input wire logic [NUM_ROWS*NUM_COLS-1:0] SETUP_DATA_I,
	input wire logic SELF_TEST_REQ_I,
	input wire logic LINK_SELF_TEST_I,
	input wire logic CODE_STORE_OK_I,
	input wire logic SCRATCH_STORE_OK_I,
	input wire logic MEM_CHECK_DONE_I,
	input wire logic KEY_OR_BUS_I,
	input wire logic RESTORE_REQ_I,
	input wire logic CONFIRM_I,
	input wire logic CANCEL_I,
	input wire logic LINK_RESTORE_I,
	output logic [STEP_W-1:0] SETUP_INDEX_O,
	output logic [STEP_W-1:0] SETUP_ADDR_O,
	output logic [NUM_ROWS*NUM_COLS-1:0] RELAY_O,
	output logic RELAY_WR_O,
	output logic SWITCH_DONE_O,
	output logic SETTLE_PENDING_WARN_O,
	output logic TRIGGER_CLASH_O,
	output logic BAD_ENTRY_O,
	output logic TRIG_ENABLED_O,
	output logic [NUM_ROWS*2-1:0] ROW_MODE_O,
	output logic LINK_MODE_WR_O,
	output logic [2:0] LINK_ROW_O,
	output logic [1:0] LINK_MODE_O,
	output logic LINK_SELF_TEST_O,
	output logic LINK_RESTORE_O,
	output logic MEM_CHECK_START_O,
	output logic CODE_STORE_FAULT_O,
	output logic SCRATCH_STORE_FAULT_O,
	output logic ALL_LAMPS_O,
	output logic CONFIRM_PROMPT_O,
	output logic [SETTLE_W-1:0] SETTLE_MS_O
);
	localparam int HOLD_W = 16;
	logic [SETTLE_W-1:0] settle_ff;
	logic [1:0] mode_ff [NUM_ROWS];
	sw_state_e sw_ff;
	sw_state_e nxt_sw;
	test_state_e st_ff;
	restore_state_e fd_ff;
	logic [MS_CNT_W-1:0] cyc_ff;
	logic [SETTLE_W-1:0] ms_ff;
	logic [HOLD_W-1:0] hold_ff;
	logic [HOLD_W-1:0] bad_cnt_ff;
	logic [NUM_ROWS*NUM_COLS-1:0] target_ff;
	logic [NUM_ROWS*NUM_COLS-1:0] relay_ff;
	logic [STEP_W-1:0] step_ff;
	logic trig_en_ff;
	logic do_restore;
	logic any_cf;
	logic any_df;
	logic ms_tick;
	logic wait_done;
	logic trig_ok;
	logic toggle_key;
	logic lone_row;

	assign do_restore = (fd_ff == FD_CONFIRM && CONFIRM_I) || LINK_RESTORE_I;
	assign toggle_key = CONNECT_FIRST_KEY_I || DISCONNECT_FIRST_KEY_I;
	assign lone_row = ROW_SEL_VALID_I && !COL_SEL_I;
	assign trig_ok = TRIGGER_I && trig_en_ff && CHAIN_LEADER_I && step_ff != STEP_LAST;

	// settling value register, out of range entries dropped
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SRST_I || do_restore)
			settle_ff <= SETTLE_RST_MS;
		else if (SETTLE_WR_I && SETTLE_MS_I <= SETTLE_MAX_MS)
			settle_ff <= SETTLE_MS_I;
	end
	assign SETTLE_MS_O = settle_ff;

	// row mode table; local keys and chain writes both land here
	always_ff @(posedge CORE_CLK_I)
	begin
		for (int r = 0; r < NUM_ROWS; r++)
		begin
			if (SRST_I || do_restore)
				mode_ff[r] <= MODE_DONT_CARE;
			else if (toggle_key && lone_row && ROW_SEL_I == r[2:0])
			begin
				if (CONNECT_FIRST_KEY_I)
					mode_ff[r] <= (mode_ff[r] == MODE_CONNECT_FIRST) ? MODE_DONT_CARE
						: MODE_CONNECT_FIRST;
				else
					mode_ff[r] <= (mode_ff[r] == MODE_DISCONNECT_FIRST) ? MODE_DONT_CARE
						: MODE_DISCONNECT_FIRST;
			end
			else if (LINK_MODE_WR_I && LINK_ROW_I == r[2:0])
				mode_ff[r] <= LINK_MODE_I;
		end
	end

	// forward local mode changes around the chain
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SRST_I)
		begin
			LINK_MODE_WR_O <= 1'b0;
			LINK_ROW_O <= 3'h0;
			LINK_MODE_O <= MODE_DONT_CARE;
		end
		else
		begin
			LINK_MODE_WR_O <= toggle_key && lone_row;
			LINK_ROW_O <= ROW_SEL_I;
			if (CONNECT_FIRST_KEY_I)
				LINK_MODE_O <= (mode_ff[ROW_SEL_I] == MODE_CONNECT_FIRST) ? MODE_DONT_CARE
					: MODE_CONNECT_FIRST;
			else
				LINK_MODE_O <= (mode_ff[ROW_SEL_I] == MODE_DISCONNECT_FIRST) ? MODE_DONT_CARE
					: MODE_DISCONNECT_FIRST;
		end
	end

	always_comb
	begin
		any_cf = 1'b0;
		any_df = 1'b0;
		for (int r = 0; r < NUM_ROWS; r++)
		begin
			ROW_MODE_O[r*2 +: 2] = mode_ff[r];
			any_cf = any_cf | (mode_ff[r] == MODE_CONNECT_FIRST);
			any_df = any_df | (mode_ff[r] == MODE_DISCONNECT_FIRST);
		end
	end

	// bad entry flag held briefly so the display can show it
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SRST_I)
			bad_cnt_ff <= '0;
		else if (toggle_key && !lone_row)
			bad_cnt_ff <= HOLD_W'(BAD_ENTRY_CYC);
		else if (bad_cnt_ff != '0)
			bad_cnt_ff <= bad_cnt_ff - 1'b1;
	end
	assign BAD_ENTRY_O = bad_cnt_ff != '0;

	// trigger enable toggle
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SRST_I || do_restore)
			trig_en_ff <= 1'b0;
		else if (TRIG_ENABLE_KEY_I)
			trig_en_ff <= !trig_en_ff;
	end
	assign TRIG_ENABLED_O = trig_en_ff;

	// millisecond prescaler, restarted on every wait
	assign ms_tick = cyc_ff == MS_CNT_W'(CYC_PER_MS - 1);

	// phase order; absent modes drop their phases
	function automatic sw_state_e after_phase(input sw_state_e cur, input logic cf,
		input logic df);
		sw_state_e n;
		n = SW_PH4;
		case (cur)
			SW_XFER: n = df ? SW_PH1 : (cf ? SW_PH2 : SW_PH4);
			SW_PH1: n = cf ? SW_PH2 : SW_PH4;
			SW_PH2: n = SW_PH3;
			default: n = SW_PH4;
		endcase
		return n;
	endfunction

	// waits: transfer, hardware interval per phase, then programmed delay
	always_comb
	begin
		case (sw_ff)
			SW_XFER: wait_done = hold_ff == HOLD_W'(XFER_CYC - 1);
			SW_PH1, SW_PH2, SW_PH3, SW_PH4: wait_done = ms_tick && ms_ff + 1'b1 >= HW_SETTLE_MS_I;
			SW_SETTLE: wait_done = ms_ff >= settle_ff;
			default: wait_done = 1'b0;
		endcase
	end

	always_comb
	begin
		nxt_sw = sw_ff;
		case (sw_ff)
			SW_IDLE: if (trig_ok) nxt_sw = SW_XFER;
			SW_XFER: if (wait_done) nxt_sw = after_phase(SW_XFER, any_cf, any_df);
			SW_PH1, SW_PH2, SW_PH3: if (wait_done) nxt_sw = after_phase(sw_ff, any_cf, any_df);
			SW_PH4: if (wait_done) nxt_sw = SW_SETTLE;
			SW_SETTLE:
				if (trig_ok)
					nxt_sw = SW_XFER;
				else if (wait_done)
					nxt_sw = SW_IDLE;
			default: nxt_sw = SW_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (SRST_I)
			sw_ff <= SW_IDLE;
		else
			sw_ff <= nxt_sw;
	end

	// counters restart on every state change
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SRST_I || nxt_sw != sw_ff)
		begin
			cyc_ff <= '0;
			ms_ff <= '0;
			hold_ff <= '0;
		end
		else
		begin
			hold_ff <= hold_ff + 1'b1;
			cyc_ff <= ms_tick ? '0 : cyc_ff + 1'b1;
			if (ms_tick && ms_ff != '1)
				ms_ff <= ms_ff + 1'b1;
		end
	end

	// setup index and latched target pattern
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SRST_I || do_restore)
		begin
			step_ff <= STEP_RST;
			target_ff <= '0;
		end
		else
		begin
			if (sw_ff == SW_IDLE && trig_ok || sw_ff == SW_SETTLE && trig_ok)
				step_ff <= step_ff + 1'b1;
			if (sw_ff == SW_XFER && hold_ff == '0)
				target_ff <= SETUP_DATA_I;
		end
	end
	assign SETUP_INDEX_O = step_ff;
	assign SETUP_ADDR_O = step_ff;

	// relay image per phase; phases 1 to 3 masked by each row's mode, phase 4 loads every row
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SRST_I || do_restore)
			relay_ff <= '0;
		else if (nxt_sw != sw_ff)
		begin
			for (int r = 0; r < NUM_ROWS; r++)
			begin
				for (int c = 0; c < NUM_COLS; c++)
				begin
					case (nxt_sw)
						SW_PH1: if (mode_ff[r] == MODE_DISCONNECT_FIRST)
							relay_ff[r*NUM_COLS+c] <= relay_ff[r*NUM_COLS+c] & target_ff[r*NUM_COLS+c];
						SW_PH2: if (mode_ff[r] == MODE_CONNECT_FIRST)
							relay_ff[r*NUM_COLS+c] <= relay_ff[r*NUM_COLS+c] | target_ff[r*NUM_COLS+c];
						SW_PH3: if (mode_ff[r] == MODE_CONNECT_FIRST)
							relay_ff[r*NUM_COLS+c] <= target_ff[r*NUM_COLS+c];
						SW_PH4: relay_ff[r*NUM_COLS+c] <= target_ff[r*NUM_COLS+c];
						default: relay_ff[r*NUM_COLS+c] <= relay_ff[r*NUM_COLS+c];
					endcase
				end
			end
		end
	end
	assign RELAY_O = relay_ff;

	// status outputs
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SRST_I)
		begin
			RELAY_WR_O <= 1'b0;
			SWITCH_DONE_O <= 1'b1;
			SETTLE_PENDING_WARN_O <= 1'b0;
			TRIGGER_CLASH_O <= 1'b0;
		end
		else
		begin
			RELAY_WR_O <= nxt_sw != sw_ff && (nxt_sw == SW_PH1 || nxt_sw == SW_PH2
				|| nxt_sw == SW_PH3 || nxt_sw == SW_PH4);
			SWITCH_DONE_O <= nxt_sw == SW_IDLE;
			SETTLE_PENDING_WARN_O <= sw_ff == SW_SETTLE && trig_ok;
			TRIGGER_CLASH_O <= TRIGGER_I && trig_en_ff && sw_ff != SW_IDLE
				&& sw_ff != SW_SETTLE;
		end
	end

	// self-check sequence; fault held until key or bus activity
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SRST_I)
			st_ff <= ST_CODE;
		else
		begin
			case (st_ff)
				ST_IDLE: if (SELF_TEST_REQ_I || LINK_SELF_TEST_I) st_ff <= ST_CODE;
				ST_CODE:
					if (MEM_CHECK_DONE_I)
						st_ff <= CODE_STORE_OK_I ? ST_SCRATCH : ST_FAULT;
				ST_SCRATCH:
					if (MEM_CHECK_DONE_I)
						st_ff <= SCRATCH_STORE_OK_I ? ST_LAMPS : ST_FAULT;
				ST_LAMPS: if (hold_ff[5:0] == 6'(LAMP_CYC - 1)) st_ff <= ST_IDLE;
				ST_FAULT: if (KEY_OR_BUS_I) st_ff <= ST_IDLE;
				default: st_ff <= ST_IDLE;
			endcase
		end
	end

	// fault kind latched while leaving the memory checks
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SRST_I || (st_ff == ST_FAULT && KEY_OR_BUS_I))
		begin
			CODE_STORE_FAULT_O <= 1'b0;
			SCRATCH_STORE_FAULT_O <= 1'b0;
		end
		else if (MEM_CHECK_DONE_I)
		begin
			if (st_ff == ST_CODE && !CODE_STORE_OK_I)
				CODE_STORE_FAULT_O <= 1'b1;
			if (st_ff == ST_SCRATCH && !SCRATCH_STORE_OK_I)
				SCRATCH_STORE_FAULT_O <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (SRST_I)
		begin
			MEM_CHECK_START_O <= 1'b0;
			ALL_LAMPS_O <= 1'b0;
			LINK_SELF_TEST_O <= 1'b0;
		end
		else
		begin
			MEM_CHECK_START_O <= st_ff == ST_CODE || st_ff == ST_SCRATCH;
			ALL_LAMPS_O <= st_ff == ST_LAMPS;
			LINK_SELF_TEST_O <= st_ff == ST_IDLE && SELF_TEST_REQ_I && CHAIN_LEADER_I;
		end
	end

	// restore needs a second confirm; cancel drops back
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SRST_I)
			fd_ff <= FD_IDLE;
		else
		begin
			case (fd_ff)
				FD_IDLE: if (RESTORE_REQ_I) fd_ff <= FD_CONFIRM;
				FD_CONFIRM: if (CANCEL_I || CONFIRM_I) fd_ff <= FD_IDLE;
				default: fd_ff <= FD_IDLE;
			endcase
		end
	end
	assign CONFIRM_PROMPT_O = fd_ff == FD_CONFIRM;

	always_ff @(posedge CORE_CLK_I)
	begin
		if (SRST_I)
			LINK_RESTORE_O <= 1'b0;
		else
			LINK_RESTORE_O <= fd_ff == FD_CONFIRM && CONFIRM_I && !CANCEL_I
				&& CHAIN_LEADER_I;
	end
endmodule

// [relay_switch_sequencer_assertions.sv]
// port checker for the relay switch sequencer
`timescale 1ns/1ps
module relay_switch_sequencer_assertions
	import relay_seq_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic SRST_I,
	input wire logic SETTLE_WR_I,
	input wire logic [SETTLE_W-1:0] SETTLE_MS_I,
	input wire logic [SETTLE_W-1:0] HW_SETTLE_MS_I,
	input wire logic ROW_SEL_VALID_I,
	input wire logic [2:0] ROW_SEL_I,
	input wire logic COL_SEL_I,
	input wire logic CONNECT_FIRST_KEY_I,
	input wire logic DISCONNECT_FIRST_KEY_I,
	input wire logic CHAIN_LEADER_I,
	input wire logic TRIG_ENABLE_KEY_I,
	input wire logic TRIGGER_I,
	input wire logic [STEP_W-1:0] SETUP_INDEX_O,
	input wire logic SWITCH_DONE_O,
	input wire logic TRIGGER_CLASH_O,
	input wire logic BAD_ENTRY_O,
	input wire logic TRIG_ENABLED_O,
	input wire logic [NUM_ROWS*2-1:0] ROW_MODE_O,
	input wire logic LINK_MODE_WR_O,
	input wire logic [2:0] LINK_ROW_O,
	input wire logic [1:0] LINK_MODE_O,
	input wire logic [SETTLE_W-1:0] SETTLE_MS_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (SRST_I);
	logic [31:0] low_cnt_ff;
	wire [1:0] sel_mode = ROW_MODE_O[ROW_SEL_I*2 +: 2];
	wire row_ok = ROW_SEL_VALID_I && !COL_SEL_I;
	wire any_key = CONNECT_FIRST_KEY_I || DISCONNECT_FIRST_KEY_I;
	// length of the current not-done stretch, to bound switching time
	always_ff @(posedge CORE_CLK_I)
		low_cnt_ff <= SWITCH_DONE_O ? 32'h0 : low_cnt_ff + 32'h1;
	sequence s_accept;
		TRIGGER_I && TRIG_ENABLED_O && CHAIN_LEADER_I && SWITCH_DONE_O
			&& SETUP_INDEX_O != STEP_LAST;
	endsequence
	sequence s_clash;
		s_accept ##2 TRIGGER_I;
	endsequence
	a_done_falls: assert property (s_accept |=> !SWITCH_DONE_O)
		else $error("done did not fall after trigger");
	a_index_step: assert property (s_accept |=> SETUP_INDEX_O == $past(SETUP_INDEX_O) + 7'h01)
		else $error("setup index did not step");
	a_clash_xfer: assert property (s_clash |=> TRIGGER_CLASH_O)
		else $error("no clash on trigger during transfer");
	a_settle_time: assert property ($rose(SWITCH_DONE_O) |-> low_cnt_ff >=
		(32'(HW_SETTLE_MS_I) + 32'(SETTLE_MS_O)) * CYC_PER_MS)
		else $error("done came before settling ended");
	a_bad_entry: assert property (any_key && !row_ok |=> BAD_ENTRY_O && $stable(ROW_MODE_O))
		else $error("bad toggle not flagged or modes changed");
	a_cf_toggle: assert property (CONNECT_FIRST_KEY_I && row_ok |=>
		ROW_MODE_O[$past(ROW_SEL_I)*2 +: 2] == ($past(sel_mode) == MODE_CONNECT_FIRST ?
		MODE_DONT_CARE : MODE_CONNECT_FIRST))
		else $error("connect-first toggle wrong");
	a_df_toggle: assert property (DISCONNECT_FIRST_KEY_I && row_ok |=>
		ROW_MODE_O[$past(ROW_SEL_I)*2 +: 2] == ($past(sel_mode) == MODE_DISCONNECT_FIRST ?
		MODE_DONT_CARE : MODE_DISCONNECT_FIRST))
		else $error("disconnect-first toggle wrong");
	a_link_fwd: assert property (any_key && row_ok && CHAIN_LEADER_I |=> LINK_MODE_WR_O
		&& LINK_ROW_O == $past(ROW_SEL_I) && LINK_MODE_O == ROW_MODE_O[LINK_ROW_O*2 +: 2])
		else $error("mode change not forwarded");
	a_enable_flip: assert property (TRIG_ENABLE_KEY_I |=> TRIG_ENABLED_O != $past(TRIG_ENABLED_O))
		else $error("enable did not toggle");
	a_settle_store: assert property (SETTLE_WR_I |=> SETTLE_MS_O ==
		($past(SETTLE_MS_I) > SETTLE_MAX_MS ? $past(SETTLE_MS_O) : $past(SETTLE_MS_I)))
		else $error("settle value stored wrongly");
endmodule
bind relay_switch_sequencer relay_switch_sequencer_assertions chk_u (.*);

// [relay_switch_sequencer_tb_top.sv]
// testbench for the relay switch sequencer
`timescale 1ns/1ps
module relay_switch_sequencer_tb_top import relay_seq_pkg::*;;
	localparam int K_WR = 0, K_CF = 1, K_DF = 2, K_EN = 3, K_TRIG = 4;
	localparam int K_REST = 5, K_CONF = 6, K_CAN = 7, K_ST = 8;
	logic CORE_CLK_I = 1'b0, SRST_I = 1'b1, ROW_SEL_VALID_I = 1'b0, COL_SEL_I = 1'b0;
	logic LINK_MODE_WR_I = 1'b0, CHAIN_LEADER_I = 1'b1, LINK_SELF_TEST_I = 1'b0;
	logic KEY_OR_BUS_I = 1'b0, LINK_RESTORE_I = 1'b0;
	logic scratch_bad_i = 1'b0;
	logic [2:0] ROW_SEL_I = 3'h0, LINK_ROW_I = 3'h0;
	logic [1:0] LINK_MODE_I = 2'h0;
	logic [15:0] SETTLE_MS_I = 16'h0000, HW_SETTLE_MS_I = 16'h0001;
	logic [8:0] keys = 9'h000;
	wire logic SETTLE_WR_I, CONNECT_FIRST_KEY_I, DISCONNECT_FIRST_KEY_I, TRIG_ENABLE_KEY_I;
	wire logic TRIGGER_I, RESTORE_REQ_I, CONFIRM_I, CANCEL_I, SELF_TEST_REQ_I;
	logic CODE_STORE_OK_I, SCRATCH_STORE_OK_I, MEM_CHECK_DONE_I, RELAY_WR_O;
	logic SWITCH_DONE_O, SETTLE_PENDING_WARN_O, TRIGGER_CLASH_O, BAD_ENTRY_O;
	logic TRIG_ENABLED_O, LINK_MODE_WR_O, LINK_SELF_TEST_O, LINK_RESTORE_O;
	logic MEM_CHECK_START_O, CODE_STORE_FAULT_O, SCRATCH_STORE_FAULT_O, ALL_LAMPS_O;
	logic CONFIRM_PROMPT_O;
	logic [6:0] SETUP_INDEX_O, SETUP_ADDR_O;
	logic [95:0] SETUP_DATA_I, RELAY_O;
	logic [15:0] ROW_MODE_O, SETTLE_MS_O;
	logic [2:0] LINK_ROW_O;
	logic [1:0] LINK_MODE_O;
	int n_mismatch = 0, checks = 0, cyc = 0;
	// one-cycle key pulses come from one vector
	assign {SELF_TEST_REQ_I, CANCEL_I, CONFIRM_I, RESTORE_REQ_I, TRIGGER_I,
		TRIG_ENABLE_KEY_I, DISCONNECT_FIRST_KEY_I, CONNECT_FIRST_KEY_I, SETTLE_WR_I} = keys;
	relay_switch_sequencer dut_u (.*);
	relay_card_model card_u (.*);
	always #20 CORE_CLK_I = ~CORE_CLK_I;
	task automatic chk(input string what, input logic [95:0] seen, input logic [95:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic press(input int k);
		@(posedge CORE_CLK_I);
		keys <= 9'h001 << k;
		@(posedge CORE_CLK_I);
		keys <= 9'h000;
		#1;
	endtask
	task automatic wr_settle(input logic [15:0] v);
		@(posedge CORE_CLK_I);
		SETTLE_MS_I <= v;
		press(K_WR);
	endtask
	task automatic test_done;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// memory checks must run before the lamps light
	task automatic t_selfcheck;
		int n;
		logic mem;
		n = 0;
		mem = 1'b0;
		while (ALL_LAMPS_O !== 1'b1 && n < 3000)
		begin
			mem |= MEM_CHECK_START_O;
			@(posedge CORE_CLK_I);
			#1;
			n++;
		end
		chk("memory check first", mem, 1'b1);
		chk("lamps on", ALL_LAMPS_O, 1'b1);
		repeat (200) @(posedge CORE_CLK_I);
		#1;
		chk("lamps off", ALL_LAMPS_O, 1'b0);
		chk("no fault", CODE_STORE_FAULT_O, 1'b0);
	endtask
	// limit entry, toggles, bad entries and a chain write
	task automatic t_entry;
		int i;
		wr_settle(16'hfde9);
		chk("settle over max", SETTLE_MS_O, 16'h0000);
		wr_settle(16'hfde8);
		chk("settle max", SETTLE_MS_O, 16'hfde8);
		@(posedge CORE_CLK_I);
		ROW_SEL_VALID_I <= 1'b1;
		ROW_SEL_I <= 3'h2;
		for (i = 0; i < 3; i++)
		begin
			press(i == 0 ? K_CF : K_DF);
			chk("row mode", ROW_MODE_O[5:4], i == 0 ? 2'h1 : i == 1 ? 2'h2 : 2'h0);
			chk("link write", LINK_MODE_WR_O, 1'b1);
		end
		ROW_SEL_VALID_I <= 1'b0;
		press(K_CF);
		chk("bad entry", BAD_ENTRY_O, 1'b1);
		ROW_SEL_VALID_I <= 1'b1;
		COL_SEL_I <= 1'b1;
		press(K_DF);
		chk("modes kept", ROW_MODE_O, 16'h0000);
		LINK_ROW_I <= 3'h5;
		LINK_MODE_I <= MODE_DISCONNECT_FIRST;
		LINK_MODE_WR_I <= 1'b1;
		@(posedge CORE_CLK_I);
		LINK_MODE_WR_I <= 1'b0;
		@(posedge CORE_CLK_I);
		#1;
		chk("chain mode", ROW_MODE_O, 16'h0800);
	endtask
	// cancel keeps settings, confirm restores the chain
	task automatic t_restore;
		logic seen;
		press(K_REST);
		chk("prompt", CONFIRM_PROMPT_O, 1'b1);
		press(K_CAN);
		chk("prompt gone", CONFIRM_PROMPT_O, 1'b0);
		chk("settle kept", SETTLE_MS_O, 16'hfde8);
		press(K_REST);
		press(K_CONF);
		seen = 1'b0;
		repeat (3)
		begin
			seen |= LINK_RESTORE_O;
			@(posedge CORE_CLK_I);
			#1;
		end
		chk("chain restore", seen, 1'b1);
		chk("settle default", SETTLE_MS_O, 16'h0000);
		chk("modes default", ROW_MODE_O, 16'h0000);
	endtask
	// scratch failure from a chain start, held until a key
	task automatic t_fault;
		@(posedge CORE_CLK_I);
		scratch_bad_i <= 1'b1;
		LINK_SELF_TEST_I <= 1'b1;
		@(posedge CORE_CLK_I);
		LINK_SELF_TEST_I <= 1'b0;
		repeat (150) @(posedge CORE_CLK_I);
		#1;
		chk("scratch fault", SCRATCH_STORE_FAULT_O, 1'b1);
		chk("code fault", CODE_STORE_FAULT_O, 1'b0);
		chk("lamps skipped", ALL_LAMPS_O, 1'b0);
		@(posedge CORE_CLK_I);
		KEY_OR_BUS_I <= 1'b1;
		scratch_bad_i <= 1'b0;
		@(posedge CORE_CLK_I);
		KEY_OR_BUS_I <= 1'b0;
		#1;
		chk("fault cleared", SCRATCH_STORE_FAULT_O, 1'b0);
	endtask
	// refused triggers, a disconnect-first switch with clash, then a trigger in settling
	task automatic t_trigger;
		int n;
		int wr;
		logic seen;
		press(K_TRIG);
		chk("disabled trigger", SETUP_INDEX_O, 7'h00);
		press(K_EN);
		chk("enabled", TRIG_ENABLED_O, 1'b1);
		@(posedge CORE_CLK_I);
		CHAIN_LEADER_I <= 1'b0;
		ROW_SEL_I <= 3'h0;
		COL_SEL_I <= 1'b0;
		press(K_TRIG);
		chk("follower trigger", SETUP_INDEX_O, 7'h00);
		chk("follower done", SWITCH_DONE_O, 1'b1);
		@(posedge CORE_CLK_I);
		CHAIN_LEADER_I <= 1'b1;
		press(K_DF);
		chk("row 0 mode", ROW_MODE_O[1:0], MODE_DISCONNECT_FIRST);
		press(K_TRIG);
		chk("done low", SWITCH_DONE_O, 1'b0);
		chk("index", SETUP_INDEX_O, 7'h01);
		press(K_TRIG);
		seen = TRIGGER_CLASH_O | SETTLE_PENDING_WARN_O;
		@(posedge CORE_CLK_I);
		#1;
		chk("clash", seen | TRIGGER_CLASH_O, 1'b1);
		n = 0;
		wr = 0;
		while (SWITCH_DONE_O !== 1'b1 && n < 60000)
		begin
			if (RELAY_WR_O === 1'b1)
				wr++;
			@(posedge CORE_CLK_I);
			#1;
			n++;
		end
		chk("done", SWITCH_DONE_O, 1'b1);
		chk("switch time", n >= 2 * CYC_PER_MS, 1'b1);
		chk("phases skipped", n < 3 * CYC_PER_MS, 1'b1);
		chk("relay writes", wr, 2);
		chk("relays", RELAY_O, {12{8'h81}});
		press(K_DF);
		chk("row 0 cleared", ROW_MODE_O, 16'h0000);
		wr_settle(16'h0001);
		press(K_TRIG);
		repeat (26000) @(posedge CORE_CLK_I);
		#1;
		chk("relays step 2", RELAY_O, {12{8'h82}});
		chk("still settling", SWITCH_DONE_O, 1'b0);
		press(K_TRIG);
		seen = SETTLE_PENDING_WARN_O;
		@(posedge CORE_CLK_I);
		#1;
		chk("warn", seen | SETTLE_PENDING_WARN_O, 1'b1);
		chk("index again", SETUP_INDEX_O, 7'h03);
	endtask
	// cycle ceiling for a hung run
	always @(posedge CORE_CLK_I)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			n_mismatch++;
			test_done();
		end
	end
	initial
	begin
		repeat (6) @(posedge CORE_CLK_I);
		SRST_I <= 1'b0;
		t_selfcheck();
		t_entry();
		t_restore();
		press(K_ST);
		chk("chain self-test", LINK_SELF_TEST_O, 1'b1);
		t_selfcheck();
		t_fault();
		t_trigger();
		test_done();
	end
endmodule
